// ===== rtl/xbar_pkg.sv
package xbar_pkg;
  localparam int NUM_XBAR_PINS = 32;
  localparam int NUM_PINS = 40;
  // Peripheral function slots in priority order
  localparam int FN_SER0_TX = 0;
  localparam int FN_SER0_RX = 1;
  localparam int FN_SCK = 2;
  localparam int FN_MISO = 3;
  localparam int FN_MOSI = 4;
  localparam int FN_NSS = 5;
  localparam int FN_SDA = 6;
  localparam int FN_SCL = 7;
  localparam int FN_CP0 = 8;
  localparam int FN_CP0A = 9;
  localparam int FN_CP1 = 10;
  localparam int FN_CP1A = 11;
  localparam int FN_SYSCK = 12;
  localparam int FN_CEX0 = 13;
  localparam int FN_ECI = 18;
  localparam int FN_T0 = 19;
  localparam int FN_T1 = 20;
  localparam int FN_TX1 = 21;
  localparam int FN_RX1 = 22;
  localparam int NUM_FN = 23;
  localparam int NUM_CEX = 5;
  localparam logic [2:0] CEX_LAST_CODE = 3'h5;
  // Fixed pins of the primary serial port
  localparam int SER0_TX_PIN = 4;
  localparam int SER0_RX_PIN = 5;
  // Select register bit positions
  localparam int SEL_SER0 = 0;
  localparam int SEL_SPI = 1;
  localparam int SEL_SMB = 2;
  localparam int SEL_SYSCK = 3;
  localparam int SEL_CP0 = 4;
  localparam int SEL_CP0A = 5;
  localparam int SEL_CP1 = 6;
  localparam int SEL_CP1A = 7;
  localparam int SEL_CEX_LSB = 0;
  localparam int SEL_ECI = 3;
  localparam int SEL_T0 = 4;
  localparam int SEL_T1 = 5;
  localparam int SEL_ROUTE_EN = 6;
  localparam int SEL_PULLUP_DIS = 7;
  localparam int SEL_UART1 = 0;
  localparam logic [1:0] NSS_4WIRE_A = 2'h2;
  localparam logic [1:0] NSS_4WIRE_B = 2'h3;
  // Reset values
  localparam logic [7:0] RST_SELECT = 8'h00;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] RST_INPUT_KIND = 8'hFF;
  localparam logic [7:0] RST_DRIVE_STYLE = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'hFF;
endpackage

// ===== rtl/priority_crossbar_port_io.sv
module priority_crossbar_port_io
  import xbar_pkg::*;
#(
  parameter int NUM_PORTS = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Configuration write strobes and data
  input wire logic sel_low_we,
  input wire logic sel_mid_we,
  input wire logic sel_high_we,
  input wire logic [7:0] sel_wdata,
  input wire logic [NUM_PORTS-1:0] skip_we,
  input wire logic [NUM_PORTS-1:0] kind_we,
  input wire logic [NUM_PORTS-1:0] style_we,
  input wire logic [NUM_PORTS-1:0] latch_we,
  input wire logic [7:0] port_wdata,
  input wire logic [1:0] slave_select_mode,
  // Peripheral side
  input wire logic [NUM_FN-1:0] periph_out,
  input wire logic [NUM_FN-1:0] periph_oe,
  output logic [NUM_FN-1:0] periph_in,
  // Pin side
  input wire logic [NUM_PORTS*8-1:0] pin_in,
  output logic [NUM_PORTS*8-1:0] pin_out,
  output logic [NUM_PORTS*8-1:0] pin_oe,
  output logic [NUM_PORTS*8-1:0] pin_pullup,
  output logic [NUM_PORTS*8-1:0] pin_digital_rx_en,
  // Readback
  output logic [NUM_PORTS*8-1:0] port_read,
  output logic [7:0] crossbar_select_low,
  output logic [7:0] crossbar_select_mid,
  output logic [7:0] crossbar_select_high,
  output logic [NUM_PORTS*8-1:0] pin_skip_mask,
  output logic [NUM_PORTS*8-1:0] pin_input_kind,
  output logic [NUM_PORTS*8-1:0] pin_drive_style,
  output logic [NUM_PORTS*8-1:0] port_latch,
  output logic [NUM_XBAR_PINS-1:0] pin_assigned
);

  localparam int NP = NUM_PORTS * 8;

  // Pin index n of port p is p*8+n throughout, so pin vectors
  // line up with the port latch and with the board wiring
  // Trade-off: placement is fully combinational. That keeps routing
  // current with every write but gives a long decode chain; at 25 MHz
  // there is ample slack for the priority scan
  logic [7:0] sel_low_q;
  logic [7:0] sel_mid_q;
  logic [7:0] sel_high_q;
  logic [NP-1:0] skip_q;
  logic [NP-1:0] kind_q;
  logic [NP-1:0] style_q;
  logic [NP-1:0] latch_q;
  logic [NP-1:0] pin_q;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------

  // All state advances only while clk_en is high
  // Low select: serial, SPI, SMBus, clock output and comparators
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_low_q <= RST_SELECT;
    end else if (clk_en && sel_low_we) begin
      sel_low_q <= sel_wdata;
    end
  end

  // Mid select: counter array, timer inputs, route enable, pull-up disable
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_mid_q <= RST_SELECT;
    end else if (clk_en && sel_mid_we) begin
      sel_mid_q <= sel_wdata;
    end
  end

  // High select: only the second serial port bit is decoded
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sel_high_q <= RST_SELECT;
    end else if (clk_en && sel_high_we) begin
      sel_high_q <= sel_wdata;
    end
  end

  // Skip masks; a set bit hides the pin from the decoder, except the fixed primary serial pins
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (sys_rst) begin
        skip_q[p*8 +: 8] <= RST_SKIP;
      end else if (clk_en && skip_we[p]) begin
        skip_q[p*8 +: 8] <= port_wdata;
      end
    end
  end

  // Input kind; every pin comes out of reset as a digital input
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (sys_rst) begin
        kind_q[p*8 +: 8] <= RST_INPUT_KIND;
      end else if (clk_en && kind_we[p]) begin
        kind_q[p*8 +: 8] <= port_wdata;
      end
    end
  end

  // Drive style; reset leaves every pin open-drain, so nothing fights the board
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (sys_rst) begin
        style_q[p*8 +: 8] <= RST_DRIVE_STYLE;
      end else if (clk_en && style_we[p]) begin
        style_q[p*8 +: 8] <= port_wdata;
      end
    end
  end

  // Port latches; reset to ones so open-drain pins float high
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (sys_rst) begin
        latch_q[p*8 +: 8] <= RST_LATCH;
      end else if (clk_en && latch_we[p]) begin
        latch_q[p*8 +: 8] <= port_wdata;
      end
    end
  end

  // Pin level sampling for port reads; one cycle of latency, but the
  // level seen by software is never a half-settled board value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_q <= '0;
    end else if (clk_en) begin
      pin_q <= pin_in;
    end
  end

  // ---------------------------------------------------------------
  // Priority decoder
  // ---------------------------------------------------------------

  // Decoder state; fn_pin holds the pin index of each placed function,
  // and is only meaningful where fn_placed is set
  logic xbar_en;
  logic weak_pud;
  logic [NUM_FN-1:0] fn_req;
  logic [NUM_XBAR_PINS-1:0] taken;
  logic [4:0] fn_pin [NUM_FN];
  logic [NUM_FN-1:0] fn_placed;
  logic [2:0] cex_sel;

  // Routing enable and pull-up disable live in the mid select register
  assign xbar_en = sel_mid_q[SEL_ROUTE_EN];
  assign weak_pud = sel_mid_q[SEL_PULLUP_DIS];
  assign cex_sel = sel_mid_q[SEL_CEX_LSB +: 3];

  // Requested functions from the select bits; a function that is
  // not requested never claims a pin, whatever its peripheral drives
  always_comb begin
    fn_req = '0;
    // Primary serial port always takes its pair
    fn_req[FN_SER0_TX] = sel_low_q[SEL_SER0];
    fn_req[FN_SER0_RX] = sel_low_q[SEL_SER0];
    // SPI: slave select only in the 4-wire configuration
    fn_req[FN_SCK] = sel_low_q[SEL_SPI];
    fn_req[FN_MISO] = sel_low_q[SEL_SPI];
    fn_req[FN_MOSI] = sel_low_q[SEL_SPI];
    fn_req[FN_NSS] = sel_low_q[SEL_SPI] &&
      (slave_select_mode == NSS_4WIRE_A || slave_select_mode == NSS_4WIRE_B);
    // SMBus takes data and clock together
    fn_req[FN_SDA] = sel_low_q[SEL_SMB];
    fn_req[FN_SCL] = sel_low_q[SEL_SMB];
    // Comparator and clock outputs
    fn_req[FN_CP0] = sel_low_q[SEL_CP0];
    fn_req[FN_CP0A] = sel_low_q[SEL_CP0A];
    fn_req[FN_CP1] = sel_low_q[SEL_CP1];
    fn_req[FN_CP1A] = sel_low_q[SEL_CP1A];
    fn_req[FN_SYSCK] = sel_low_q[SEL_SYSCK];
    // Counter-array channels; reserved codes route nothing
    for (int c = 0; c < NUM_CEX; c++) begin
      fn_req[FN_CEX0 + c] = (cex_sel <= CEX_LAST_CODE) && (cex_sel > 3'(c));
    end
    // Timer and counter inputs
    fn_req[FN_ECI] = sel_mid_q[SEL_ECI];
    fn_req[FN_T0] = sel_mid_q[SEL_T0];
    fn_req[FN_T1] = sel_mid_q[SEL_T1];
    // Second serial port takes its pair
    fn_req[FN_TX1] = sel_high_q[SEL_UART1];
    fn_req[FN_RX1] = sel_high_q[SEL_UART1];
  end

  // Combinational placement: purely a function of current settings, so the
  // routing follows every register change in the same cycle
  // A function that finds no free pin is simply not placed; software
  // must skip fewer pins or enable fewer functions in that case
  always_comb begin
    taken = skip_q[NUM_XBAR_PINS-1:0];
    fn_placed = '0;
    for (int f = 0; f < NUM_FN; f++) begin
      fn_pin[f] = '0;
    end
    // Primary serial pins are fixed regardless of skip, so a boot loader
    // always finds them where it expects
    if (fn_req[FN_SER0_TX]) begin
      taken[SER0_TX_PIN] = 1'b1;
      taken[SER0_RX_PIN] = 1'b1;
      fn_pin[FN_SER0_TX] = 5'(SER0_TX_PIN);
      fn_pin[FN_SER0_RX] = 5'(SER0_RX_PIN);
      fn_placed[FN_SER0_TX] = 1'b1;
      fn_placed[FN_SER0_RX] = 1'b1;
    end
    // Remaining functions each take the lowest free pin, in order;
    // scanning down from the top leaves the lowest free pin last
    for (int f = FN_SCK; f < NUM_FN; f++) begin
      if (fn_req[f]) begin
        for (int n = NUM_XBAR_PINS - 1; n >= 0; n--) begin
          if (!taken[n]) begin
            fn_pin[f] = 5'(n);
            fn_placed[f] = 1'b1;
          end
        end
        if (fn_placed[f]) begin
          taken[fn_pin[f]] = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------

  // drv_val and drv_en: what each pin would drive before the cell gating;
  // port_live: whether the pin's port may drive at all
  logic [NP-1:0] drv_val;
  logic [NP-1:0] drv_en;
  logic [NP-1:0] od_force;
  logic [NP-1:0] push_pull;
  logic [NP-1:0] port_live;
  logic [NP-1:0] drive_low;
  logic [NP-1:0] drive_high;

  // Peripheral overlay onto crossbar pins; unassigned pins stay GPIO.
  // A placed function drives only while its peripheral asks to, so
  // an idle peripheral leaves the pin floating or pulled up
  always_comb begin
    drv_val = latch_q;
    drv_en = '1;
    pin_assigned = '0;
    for (int f = 0; f < NUM_FN; f++) begin
      if (xbar_en && fn_placed[f]) begin
        pin_assigned[fn_pin[f]] = 1'b1;
        drv_val[fn_pin[f]] = periph_out[f];
        drv_en[fn_pin[f]] = periph_oe[f];
      end
    end
  end

  // SMBus lines never drive high, so a slave holding low cannot short them
  always_comb begin
    od_force = '0;
    if (xbar_en && fn_placed[FN_SDA]) begin
      od_force[fn_pin[FN_SDA]] = 1'b1;
    end
    if (xbar_en && fn_placed[FN_SCL]) begin
      od_force[fn_pin[FN_SCL]] = 1'b1;
    end
  end

  // Return path; analog pins hand a zero to their peripheral
  always_comb begin
    periph_in = '0;
    for (int f = 0; f < NUM_FN; f++) begin
      if (xbar_en && fn_placed[f]) begin
        periph_in[f] = pin_q[fn_pin[f]] & kind_q[fn_pin[f]];
      end
    end
  end

  // Forced open-drain overrides the style bit
  assign push_pull = style_q & ~od_force;

  // ---------------------------------------------------------------
  // Pin cells
  // ---------------------------------------------------------------

  // Ports 0-3 go dark while routing is off; port 4 never takes part.
  // Limitation: port 4 has no crossbar pins, so its enable is fixed
  always_comb begin
    port_live = '1;
    port_live[NUM_XBAR_PINS-1:0] = {NUM_XBAR_PINS{xbar_en}};
  end

  // Open-drain pins only pull low; push-pull pins drive either level,
  // and an analog pin never drives at all
  always_comb begin
    for (int n = 0; n < NP; n++) begin
      drive_low[n] = port_live[n] && kind_q[n] && drv_en[n] && !drv_val[n];
      drive_high[n] = port_live[n] && kind_q[n] && drv_en[n] && drv_val[n] &&
        push_pull[n];
      pin_out[n] = drv_val[n] && push_pull[n];
      pin_oe[n] = drive_low[n] || drive_high[n];
    end
  end

  // Pull-up only on digital open-drain pins not pulling low; it would
  // otherwise burn current against the driver for nothing
  always_comb begin
    for (int n = 0; n < NP; n++) begin
      pin_pullup[n] = !weak_pud && kind_q[n] && !push_pull[n] && !drive_low[n];
    end
  end

  // Receivers off on analog pins; analog pins read as zero, digital pins
  // read the sampled level, whether or not a peripheral owns the pin
  always_comb begin
    for (int n = 0; n < NP; n++) begin
      pin_digital_rx_en[n] = kind_q[n];
      port_read[n] = pin_q[n] & kind_q[n];
    end
  end

  // ---------------------------------------------------------------
  // Readback
  // ---------------------------------------------------------------

  // Registers are wired straight out so software reads what it wrote;
  // unused high select bits read back as written
  assign crossbar_select_low = sel_low_q;
  assign crossbar_select_mid = sel_mid_q;
  assign crossbar_select_high = sel_high_q;
  assign pin_skip_mask = skip_q;
  assign pin_input_kind = kind_q;
  assign pin_drive_style = style_q;
  assign port_latch = latch_q;

endmodule

// ===== testbench/priority_crossbar_port_io_properties.sv
// ----------------------------------------
// Pin-side relations of the crossbar block
// ----------------------------------------
module priority_crossbar_port_io_properties
  import xbar_pkg::*;
#(
  parameter int NUM_PORTS = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [NUM_PORTS*8-1:0] pin_in,
  input wire logic [NUM_PORTS*8-1:0] pin_out,
  input wire logic [NUM_PORTS*8-1:0] pin_oe,
  input wire logic [NUM_PORTS*8-1:0] pin_pullup,
  input wire logic [NUM_PORTS*8-1:0] pin_digital_rx_en,
  input wire logic [NUM_PORTS*8-1:0] port_read,
  input wire logic [7:0] crossbar_select_low,
  input wire logic [7:0] crossbar_select_mid,
  input wire logic [NUM_PORTS*8-1:0] pin_input_kind,
  input wire logic [NUM_PORTS*8-1:0] pin_drive_style,
  input wire logic [NUM_PORTS*8-1:0] port_latch,
  input wire logic [NUM_XBAR_PINS-1:0] pin_assigned
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Analog pins must be fully quiet
  AST_ANALOG_OFF: assert property ((~pin_input_kind & (pin_pullup | pin_oe)) == '0)
    else $error("analog pin drives or pulls up");
  AST_RX_EN: assert property (pin_digital_rx_en == pin_input_kind)
    else $error("receiver enable differs from input kind");
  AST_DISABLED: assert property (!crossbar_select_mid[SEL_ROUTE_EN] |->
    pin_oe[31:0] == '0 && pin_assigned == '0) else $error("disabled crossbar drives");
  AST_SER0_FIXED: assert property (crossbar_select_mid[SEL_ROUTE_EN] &&
    crossbar_select_low[SEL_SER0] |-> pin_assigned[SER0_TX_PIN] && pin_assigned[SER0_RX_PIN])
    else $error("serial pins not fixed");
  // Pull-up off while pulling low, else a needless current path
  AST_PULLUP_LOW: assert property ((pin_pullup & pin_oe & ~pin_out) == '0)
    else $error("pull-up on while driving low");
  AST_OD_NO_HIGH: assert property ((pin_oe & pin_out & ~pin_drive_style) == '0)
    else $error("open-drain pin drives high");
  AST_PORT4_GPIO: assert property (pin_oe[39:32] == (pin_input_kind[39:32] &
    (pin_drive_style[39:32] | ~port_latch[39:32]))) else $error("port 4 drive wrong");
  AST_PORT4_PULLUP: assert property (pin_pullup[39:32] ==
    ({8{!crossbar_select_mid[SEL_PULLUP_DIS]}} &
    pin_input_kind[39:32] & ~pin_drive_style[39:32] & port_latch[39:32]))
    else $error("port 4 pull-up wrong");
  AST_READ_LEVEL: assert property (!$past(sys_rst) && $past(clk_en) |->
    port_read == ($past(pin_in) & pin_input_kind)) else $error("port read not pin level");
endmodule

// ===== testbench/pin_board_model.sv
// --------------------------------
// Board wiring seen by the pins
// --------------------------------
module pin_board_model (
  input wire logic clk,
  input wire logic [39:0] pin_out,
  input wire logic [39:0] pin_oe,
  input wire logic [39:0] pin_pullup,
  input wire logic [39:0] board_drive,
  input wire logic [39:0] board_level,
  output logic [39:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [39:0] float_q = 40'hAA_AAAA_AAAA;
  // A floating pin must never look stable to the design
  always @(posedge clk) float_q <= ~float_q;
  // Device wins, then the board, then pull-up or float
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_drive & board_level) |
    (~pin_oe & ~board_drive & (pin_pullup | float_q));
endmodule

// ===== testbench/priority_crossbar_port_io_tb.sv
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
// --------------------------------
// Crossbar bench
// --------------------------------
module priority_crossbar_port_io_tb;
  import xbar_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic sel_low_we = 1'h0, sel_mid_we = 1'h0, sel_high_we = 1'h0;
  logic [7:0] sel_wdata = 8'h00, s_lo, s_mid, s_hi;
  logic [4:0] skip_we = 5'h00, kind_we = 5'h00, style_we = 5'h00, latch_we = 5'h00;
  logic [1:0] ssm = 2'h0;
  logic ce = 1'h1;
  logic [NUM_FN-1:0] p_out = 23'h0, p_oe = 23'h0, p_in;
  logic [39:0] pin_in, pin_out, pin_oe, pin_pu, rx_en, rd, skip_m, kind_m, style_m, latch_m;
  logic [39:0] brd_drv = 40'h0, brd_lvl = 40'h0;
  logic [31:0] asg;
  int n_fail = 0;
  int samples_checked = 0;
  priority_crossbar_port_io i_priority_crossbar_port_io (.clk(clk), .sys_rst(sys_rst),
    .clk_en(ce), .sel_low_we(sel_low_we), .sel_mid_we(sel_mid_we),
    .sel_high_we(sel_high_we), .sel_wdata(sel_wdata), .skip_we(skip_we), .kind_we(kind_we),
    .style_we(style_we), .latch_we(latch_we), .port_wdata(sel_wdata),
    .slave_select_mode(ssm), .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pu),
    .pin_digital_rx_en(rx_en), .port_read(rd), .crossbar_select_low(s_lo),
    .crossbar_select_mid(s_mid), .crossbar_select_high(s_hi), .pin_skip_mask(skip_m),
    .pin_input_kind(kind_m), .pin_drive_style(style_m), .port_latch(latch_m),
    .pin_assigned(asg));
  pin_board_model i_pin_board_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pu), .board_drive(brd_drv), .board_level(brd_lvl), .pin_in(pin_in));
  // Clock at 25 MHz
  initial forever #20 clk = ~clk;
  // One-cycle strobe; k: 0 low 1 mid 2 high 3 skip 4 kind 5 style 6 latch
  task automatic wr(input int k, input int p, input logic [7:0] d);
    @(negedge clk);
    sel_wdata = d;
    case (k)
      0: sel_low_we = 1'h1;
      1: sel_mid_we = 1'h1;
      2: sel_high_we = 1'h1;
      3: skip_we[p] = 1'h1;
      4: kind_we[p] = 1'h1;
      5: style_we[p] = 1'h1;
      default: latch_we[p] = 1'h1;
    endcase
    @(negedge clk);
    {sel_low_we, sel_mid_we, sel_high_we} = 3'h0;
    {skip_we, kind_we, style_we, latch_we} = 20'h0;
  endtask
  task automatic rst(input int n);
    @(negedge clk);
    sys_rst = 1'h1;
    {p_out, p_oe, brd_drv, ssm} = 88'h0;
    repeat (n) @(negedge clk);
    sys_rst = 1'h0;
  endtask
  task automatic t_reset();
    @(negedge clk);
    `CHK("kind", 40'hFF_FFFF_FFFF, kind_m)
    `CHK("skip", 40'h0, skip_m)
    `CHK("pu4", 48'h0000_0000_00FF, {pin_oe, pin_pu[39:32]})
    $display("t_reset done");
  endtask
  // Software order kept: style, skip, select, then enable
  task automatic t_uart_smb();
    wr(5, 0, 8'hFF);
    wr(3, 0, 8'h31);
    wr(0, 0, 8'h05);
    wr(1, 0, 8'h40);
    `CHK("asg", 32'h36, asg)
    {p_oe[FN_SER0_TX], p_out[FN_SER0_TX], p_oe[FN_SDA], p_out[FN_SDA]} = 4'hF;
    #1;
    `CHK("tx", 2'h3, {pin_oe[SER0_TX_PIN], pin_out[SER0_TX_PIN]})
    `CHK("sda1", 2'h1, {pin_oe[1], pin_pu[1]})
    p_out[FN_SDA] = 1'h0;
    #1;
    `CHK("sda0", 3'h4, {pin_oe[1], pin_out[1], pin_pu[1]})
    for (int v = 0; v < 2; v++) begin
      brd_drv[SER0_RX_PIN] = 1'h1;
      brd_lvl[SER0_RX_PIN] = v[0];
      @(negedge clk);
      `CHK("rx", {v[0], v[0]}, {p_in[FN_SER0_RX], rd[SER0_RX_PIN]})
    end
    $display("t_uart_smb done");
  endtask
  task automatic t_spi();
    wr(3, 0, 8'h03);
    wr(0, 0, 8'h06);
    wr(1, 0, 8'h40);
    for (int m = 0; m < 4; m++) begin
      ssm = m[1:0];
      @(negedge clk);
      `CHK("spi", m[1] ? 32'hFC : 32'h7C, asg)
    end
    $display("t_spi done");
  endtask
  task automatic t_pca();
    for (int n = 0; n < 8; n++) begin
      wr(1, 0, 8'h40 | n[7:0]);
      `CHK("pca", n < 6 ? (32'h1 << n) - 32'h1 : 32'h0, asg)
    end
    wr(2, 0, 8'h01);
    `CHK("u1", 40'h01_0000_0003, {s_hi, asg})
    $display("t_pca done");
  endtask
  task automatic t_gpio();
    wr(0, 0, 8'h01);
    wr(6, 0, 8'h00);
    wr(6, 4, 8'h00);
    `CHK("off", 72'hFF_0000_0000_0000_0000, {pin_oe, asg})
    `CHK("lat", 16'h0000, {latch_m[39:32], latch_m[7:0]})
    wr(1, 0, 8'h40);
    `CHK("on", 48'hFF_0000_00CF_00, {pin_oe, pin_pu[39:32]})
    $display("t_gpio done");
  endtask
  task automatic t_analog();
    wr(4, 4, 8'hF0);
    brd_drv = 40'hFF_0000_0000;
    brd_lvl = 40'hFF_0000_0000;
    @(negedge clk);
    `CHK("an", 24'hF0F0F0, {rd[39:32], pin_pu[39:32], rx_en[39:32]})
    wr(1, 0, 8'h80);
    `CHK("wpd", 8'h00, pin_pu[39:32])
    ce = 1'h0;
    wr(1, 0, 8'h40);
    `CHK("freeze", 40'h80_0000_0000, {s_mid, asg})
    ce = 1'h1;
    $display("t_analog done");
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence, a short reset between scenarios
  initial begin
    rst(12);
    t_reset();
    t_uart_smb();
    rst(2);
    t_spi();
    rst(2);
    t_pca();
    rst(2);
    t_gpio();
    rst(2);
    t_analog();
    wrap_up();
  end
  // Watchdog: the run needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule
bind priority_crossbar_port_io priority_crossbar_port_io_properties #(.NUM_PORTS(NUM_PORTS))
  i_props (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
  .pin_digital_rx_en(pin_digital_rx_en), .port_read(port_read),
  .crossbar_select_low(crossbar_select_low), .crossbar_select_mid(crossbar_select_mid),
  .pin_input_kind(pin_input_kind), .pin_drive_style(pin_drive_style),
  .port_latch(port_latch), .pin_assigned(pin_assigned));
